// ==== nmea_cfg_pkg.sv ====
// Constants, encodings and register map for the setup sentence interpreter
`default_nettype none
package nmea_cfg_pkg;
  // Characters
  localparam logic [7:0] CH_DOLLAR = 8'h24;
  localparam logic [7:0] CH_COMMA  = 8'h2C;
  localparam logic [7:0] CH_STAR   = 8'h2A;
  localparam logic [7:0] CH_CR     = 8'h0D;
  localparam logic [7:0] CH_LF     = 8'h0A;
  localparam logic [7:0] CH_ZERO   = 8'h30;
  localparam logic [7:0] CH_NINE   = 8'h39;
  localparam logic [7:0] CH_TWO    = 8'h32;
  localparam logic [7:0] CH_THREE  = 8'h33;
  localparam logic [7:0] CH_FOUR   = 8'h34;
  localparam logic [7:0] CH_ONE    = 8'h31;
  localparam logic [7:0] CH_A      = 8'h41;
  localparam logic [7:0] CH_D      = 8'h44;
  localparam logic [7:0] CH_G      = 8'h47;
  // Five-character sentence names, ASCII packed first char high
  localparam logic [39:0] NAME_SETUP  = 40'h5047524D43;
  localparam logic [39:0] NAME_SELECT = 40'h5047524D4F;
  localparam logic [39:0] NAME_RMC    = 40'h4750524D43;
  localparam logic [39:0] NAME_GGA    = 40'h4750474741;
  localparam logic [39:0] NAME_GSA    = 40'h4750475341;
  localparam logic [39:0] NAME_GSV    = 40'h4750475356;
  localparam logic [39:0] NAME_ERR    = 40'h5047524D45;
  localparam logic [39:0] NAME_GLL    = 40'h4750474C4C;
  localparam logic [39:0] NAME_VTG    = 40'h4750565447;
  localparam logic [39:0] NAME_ALM    = 40'h4750414C4D;
  localparam logic [39:0] NAME_BEACON = 40'h50534C4942;
  // Output sentence bits, index is transmit order
  localparam int NSENT = 9;
  localparam int B_RMC = 0, B_GGA = 1, B_GSA = 2, B_GSV = 3, B_ERR = 4;
  localparam int B_GLL = 5, B_VTG = 6, B_ALM = 7, B_BEACON = 8;
  localparam logic [8:0] MASK_SHIPPED = 9'h002;
  localparam logic [8:0] MASK_FACTORY = 9'h01F;
  localparam logic [8:0] MASK_ALL     = 9'h17F;
  localparam logic [8:0] MASK_BEACON  = 9'h100;
  // Longest length of each periodic sentence in characters
  localparam logic [6:0] MAXC_RMC = 7'd74, MAXC_GGA = 7'd82, MAXC_GSA = 7'd66;
  localparam logic [6:0] MAXC_GSV = 7'd70, MAXC_ERR = 7'd35, MAXC_GLL = 7'd44;
  localparam logic [6:0] MAXC_VTG = 7'd42;
  localparam logic [3:0] BITS_PER_CHAR = 4'd10;
  // Shipped operating values, field limits and encodings
  localparam logic [1:0] FIX_AUTO = 2'd0, FIX_2D = 2'd1, FIX_3D = 2'd2;
  localparam logic [2:0] BAUD_SHIPPED  = 3'd1;
  localparam logic [5:0] PPSW_SHIPPED  = 6'd3;
  localparam logic [4:0] DR_SHIPPED    = 5'd30;
  localparam logic [5:0] PPSW_MAX      = 6'd48;
  localparam logic [4:0] DR_MAX        = 5'd30;
  localparam logic [2:0] BAUD_MAX      = 3'd7;
  localparam logic [9:0] PPS_STEP_MS   = 10'd20;
  localparam logic [3:0] NAME_LEN      = 4'd5;
  // Register byte offsets
  localparam logic [7:0] REG_SETUP  = 8'h00;
  localparam logic [7:0] REG_PORT   = 8'h04;
  localparam logic [7:0] REG_OUTEN  = 8'h08;
  localparam logic [7:0] REG_CTRL   = 8'h0C;
  localparam logic [7:0] REG_STATS  = 8'h10;
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  typedef enum logic [1:0] {KIND_NONE, KIND_SETUP, KIND_SELECT} cmd_kind_t;
endpackage
`default_nettype wire

// ==== nmea_host_model.sv ====
// Host terminal model that types sentences into the interpreter
`default_nettype none
module nmea_host_model
  import nmea_cfg_pkg::*;
(
  input  wire logic       i_clk_sys,
  output var  logic       o_rx_valid,
  output var  logic [7:0] o_rx_char
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    o_rx_valid = 1'b0;
    o_rx_char  = 8'h00;
  end
  // One char per cycle; no checksum appended
  task automatic send(input logic [39:0] nm, input string f, input bit term);
    logic [7:0] q[$];
    q.push_back(CH_DOLLAR);
    for (int i = 4; i >= 0; i--)
      q.push_back(nm[i*8 +: 8]);
    for (int i = 0; i < f.len(); i++)
      q.push_back(8'(f[i]));
    if (term)
    begin
      q.push_back(CH_CR);
      q.push_back(CH_LF);
    end
    foreach (q[i])
    begin
      @(posedge i_clk_sys);
      o_rx_valid <= 1'b1;
      o_rx_char  <= q[i];
    end
    @(posedge i_clk_sys);
    o_rx_valid <= 1'b0;
    // Idle line shows junk so stale chars cannot pass
    o_rx_char  <= ~q[q.size()-1];
  endtask
endmodule
`default_nettype wire

// ==== nmea_setup_parser.sv ====
// Setup and output-select sentence interpreter with AHB-Lite register slave
//
// Contract
// [RULE1] Reset: GGA only, code-1 baud, pulse enabled, 80 ms pulse width.
// [RULE2] Empty field leaves its operating parameter unchanged.
// [RULE3] Carriage return then line feed completes a sentence.
// [RULE4] Trailing asterisk and checksum are optional and never checked.
// [RULE5] Setup field 1: A automatic, 2 two-dimensional, 3 three-dimensional.
// [RULE6] Setup field 9: A automatic, D differential only.
// [RULE7] Setup field 10: baud codes 1 to 7.
// [RULE8] Setup field 11: 0 off, 1 automatic, 2-255 time constant.
// [RULE9] Setup field 12: 1 no pulse, 2 one pulse per second.
// [RULE10] Setup field 13: n 0..48, width (n+1) times 20 ms.
// [RULE11] Setup field 14: dead-reckoning valid time 1..30 seconds.
// [RULE12] Baud and pulse mode wait for restart; others apply at once.
// [RULE13] Select modes: 0 off, 1 on, 2 beacon only, 3 all but almanac, 4 factory.
// [RULE14] Modes 2-4 accept any name of up to five characters or empty.
// [RULE15] Modes 0 and 1 need a known sentence name.
// [RULE16] Any invalid select field discards the whole sentence.
// [RULE17] Almanac enable sends almanac and suspends periodic output until done.
// [RULE18] Empty name with mode G switches port to binary until reset.
// [RULE19] Fixed sentence order with bounded lengths; GLL off by default.
// [RULE20] Burst length is ten bit times per character, back to back.
// [RULE21] Wait for dollar; commas split fields; asterisk starts checksum.
`default_nettype none
module nmea_setup_parser
  import nmea_cfg_pkg::*;
(
  input  wire logic        i_clk_sys,
  input  wire logic        i_reset,
  input  wire logic        i_rx_valid,
  input  wire logic [7:0]  i_rx_char,
  input  wire logic        i_restart_evt,
  input  wire logic        i_almanac_done,
  input  wire logic        i_hsel,
  input  wire logic [7:0]  i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic        i_hready,
  input  wire logic [31:0] i_hwdata,
  output logic [31:0]      o_hrdata,
  output logic             o_hreadyout,
  output logic             o_hresp,
  output logic [1:0]       o_fix_mode,
  output logic             o_diff_only,
  output logic [7:0]       o_vel_filter,
  output logic [4:0]       o_dr_time_s,
  output logic [2:0]       o_baud_code,
  output logic             o_pps_enable,
  output logic [9:0]       o_pps_width_ms,
  output logic [8:0]       o_out_enable,
  output logic             o_almanac_busy,
  output logic             o_binary_mode,
  output logic [15:0]      o_burst_bits,
  output logic             o_cmd_done
);
  import nmea_cfg_pkg::*;

  typedef enum logic [1:0] {ST_HUNT, ST_BODY, ST_CKSUM, ST_LF} pstate_t;

  function automatic logic [8:0] name_bit(input logic [39:0] nm);
    logic [8:0] b;
    b = '0;
    unique case (nm)
      NAME_RMC:    b[B_RMC] = 1'b1;
      NAME_GGA:    b[B_GGA] = 1'b1;
      NAME_GSA:    b[B_GSA] = 1'b1;
      NAME_GSV:    b[B_GSV] = 1'b1;
      NAME_ERR:    b[B_ERR] = 1'b1;
      NAME_GLL:    b[B_GLL] = 1'b1;
      NAME_VTG:    b[B_VTG] = 1'b1;
      NAME_ALM:    b[B_ALM] = 1'b1;
      NAME_BEACON: b[B_BEACON] = 1'b1;
      default:     b = '0;
    endcase
    return b;
  endfunction

  function automatic logic [15:0] burst_of(input logic [8:0] m);
    logic [12:0] c;
    c = '0;
    if (m[B_RMC]) c = c + 13'(MAXC_RMC);
    if (m[B_GGA]) c = c + 13'(MAXC_GGA);
    if (m[B_GSA]) c = c + 13'(MAXC_GSA);
    if (m[B_GSV]) c = c + 13'(MAXC_GSV);
    if (m[B_ERR]) c = c + 13'(MAXC_ERR);
    if (m[B_GLL]) c = c + 13'(MAXC_GLL);
    if (m[B_VTG]) c = c + 13'(MAXC_VTG);
    return 16'(c * BITS_PER_CHAR);
  endfunction

  pstate_t    pst_q;
  cmd_kind_t  kind_q;
  logic [3:0] fidx_q;
  logic [3:0] flen_q;
  logic [39:0] fname_q;
  logic [7:0] fchar_q;
  logic [8:0] fval_q;
  logic       fnum_q;
  // Staged setup values, each with a present flag
  logic [1:0] s_fix_q;
  logic       s_fix_v_q, s_diff_q, s_diff_v_q;
  logic [2:0] s_baud_q;
  logic       s_baud_v_q;
  logic [7:0] s_vf_q;
  logic       s_vf_v_q, s_ppsm_q, s_ppsm_v_q;
  logic [5:0] s_ppsw_q;
  logic       s_ppsw_v_q;
  logic [4:0] s_dr_q;
  logic       s_dr_v_q;
  // Staged select fields
  logic [39:0] sel_name_q;
  logic [3:0]  sel_nlen_q;
  logic [7:0]  sel_mode_q;
  logic [3:0]  sel_mlen_q;
  // Operating state
  logic [1:0] fix_q;
  logic       diff_q;
  logic [7:0] vf_q;
  logic [5:0] ppsw_q;
  logic [4:0] dr_q;
  logic [2:0] baud_q, baud_pend_q;
  logic       pps_q, pps_pend_q;
  logic [8:0] mask_q;
  logic       alm_q, bin_q;
  logic [7:0] n_ok_q, n_bad_q;
  // Bus
  logic       wr_pend_q;
  logic [7:0] wr_addr_q;

  logic rx_delim, rx_digit, num_ok, commit, done_ok;
  logic sel_valid, sel_alm;
  logic [8:0] sel_bit;
  logic [11:0] acc_next;
  logic [8:0] new_mask;

  assign rx_delim = (i_rx_char == CH_COMMA) || (i_rx_char == CH_STAR)
                    || (i_rx_char == CH_CR);
  assign rx_digit = (i_rx_char >= CH_ZERO) && (i_rx_char <= CH_NINE);
  assign acc_next = 12'(fval_q) * 12'd10 + 12'(i_rx_char - CH_ZERO);
  assign num_ok   = fnum_q && (flen_q != 4'd0);
  assign commit   = i_rx_valid && (pst_q == ST_BODY) && rx_delim;
  assign done_ok  = i_rx_valid && (pst_q == ST_LF) && (i_rx_char == CH_LF); // [RULE3]
  assign sel_bit  = name_bit(sel_name_q);

  // Select sentence validation and resulting output mask
  always_comb
  begin
    sel_valid = 1'b0;
    sel_alm   = 1'b0;
    new_mask  = mask_q;
    if (sel_mlen_q == 4'd1)
    begin
      unique case (sel_mode_q)
        CH_ZERO, CH_ONE:
        begin
          if (sel_nlen_q == NAME_LEN && sel_bit != '0) // [RULE15]
          begin
            sel_valid = 1'b1;
            if (sel_mode_q == CH_ZERO)
              new_mask = mask_q & ~sel_bit;
            else if (sel_bit[B_ALM])
              sel_alm = 1'b1; // [RULE17]
            else
              new_mask = mask_q | sel_bit;
          end
        end
        CH_TWO, CH_THREE, CH_FOUR:
        begin
          sel_valid = (sel_nlen_q <= NAME_LEN); // [RULE14]
          if (sel_mode_q == CH_TWO)
            new_mask = MASK_BEACON; // [RULE13]
          else if (sel_mode_q == CH_THREE)
            new_mask = MASK_ALL;
          else
            new_mask = MASK_FACTORY;
        end
        CH_G:
          sel_valid = (sel_nlen_q == 4'd0); // [RULE18]
        default:
          sel_valid = 1'b0;
      endcase
    end
    if (!sel_valid)
      new_mask = mask_q; // [RULE16]
  end

  // Sentence framing
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
      pst_q <= ST_HUNT;
    else if (i_rx_valid)
    begin
      if (i_rx_char == CH_DOLLAR)
        pst_q <= ST_BODY; // [RULE21]
      else
      begin
        unique case (pst_q)
          ST_HUNT:  pst_q <= ST_HUNT;
          ST_BODY:
            if (i_rx_char == CH_CR)
              pst_q <= ST_LF;
            else if (i_rx_char == CH_STAR)
              pst_q <= ST_CKSUM; // [RULE4]
          ST_CKSUM:
            if (i_rx_char == CH_CR)
              pst_q <= ST_LF;
          ST_LF:    pst_q <= ST_HUNT;
        endcase
      end
    end
  end

  // Field accumulation
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset || (i_rx_valid && (i_rx_char == CH_DOLLAR)) || commit)
    begin
      flen_q  <= '0;
      fname_q <= '0;
      fchar_q <= '0;
      fval_q  <= '0;
      fnum_q  <= 1'b1;
    end
    else if (i_rx_valid && pst_q == ST_BODY)
    begin
      // Saturate so long names cannot alias a valid length
      if (flen_q != 4'hF)
        flen_q <= flen_q + 4'd1;
      fname_q <= {fname_q[31:0], i_rx_char};
      if (flen_q == 4'd0)
        fchar_q <= i_rx_char;
      if (!rx_digit || acc_next > 12'd255)
        fnum_q <= 1'b0;
      else
        fval_q <= acc_next[8:0];
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset || (i_rx_valid && (i_rx_char == CH_DOLLAR)))
    begin
      fidx_q <= '0;
      kind_q <= KIND_NONE;
    end
    else if (commit)
    begin
      if (fidx_q != 4'hF)
        fidx_q <= fidx_q + 4'd1; // [RULE21]
      if (fidx_q == 4'd0)
      begin
        if (flen_q == NAME_LEN && fname_q == NAME_SETUP)
          kind_q <= KIND_SETUP;
        else if (flen_q == NAME_LEN && fname_q == NAME_SELECT)
          kind_q <= KIND_SELECT;
      end
    end
  end

  // Setup staging; a field only stages when present and in range
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset || (i_rx_valid && (i_rx_char == CH_DOLLAR)))
    begin
      {s_fix_v_q, s_diff_v_q, s_baud_v_q, s_vf_v_q} <= '0; // [RULE2]
      {s_ppsm_v_q, s_ppsw_v_q, s_dr_v_q} <= '0;
      s_fix_q  <= FIX_AUTO;
      s_diff_q <= 1'b0;
      s_baud_q <= BAUD_SHIPPED;
      s_vf_q   <= '0;
      s_ppsm_q <= 1'b1;
      s_ppsw_q <= PPSW_SHIPPED;
      s_dr_q   <= DR_SHIPPED;
    end
    else if (commit && kind_q == KIND_SETUP && flen_q != 4'd0)
    begin
      unique case (fidx_q)
        4'd1:
          if (flen_q == 4'd1 && (fchar_q == CH_A || fchar_q == CH_TWO
                                 || fchar_q == CH_THREE))
          begin
            s_fix_v_q <= 1'b1; // [RULE5]
            s_fix_q   <= (fchar_q == CH_A) ? FIX_AUTO
                         : (fchar_q == CH_TWO) ? FIX_2D : FIX_3D;
          end
        4'd9:
          if (flen_q == 4'd1 && (fchar_q == CH_A || fchar_q == CH_D))
          begin
            s_diff_v_q <= 1'b1; // [RULE6]
            s_diff_q   <= (fchar_q == CH_D);
          end
        4'd10:
          if (num_ok && fval_q >= 9'd1 && fval_q <= 9'(BAUD_MAX))
          begin
            s_baud_v_q <= 1'b1; // [RULE7]
            s_baud_q   <= fval_q[2:0];
          end
        4'd11:
          if (num_ok)
          begin
            s_vf_v_q <= 1'b1; // [RULE8]
            s_vf_q   <= fval_q[7:0];
          end
        4'd12:
          if (num_ok && (fval_q == 9'd1 || fval_q == 9'd2))
          begin
            s_ppsm_v_q <= 1'b1; // [RULE9]
            s_ppsm_q   <= (fval_q == 9'd2);
          end
        4'd13:
          if (num_ok && fval_q <= 9'(PPSW_MAX))
          begin
            s_ppsw_v_q <= 1'b1; // [RULE10]
            s_ppsw_q   <= fval_q[5:0];
          end
        4'd14:
          if (num_ok && fval_q >= 9'd1 && fval_q <= 9'(DR_MAX))
          begin
            s_dr_v_q <= 1'b1; // [RULE11]
            s_dr_q   <= fval_q[4:0];
          end
        default: ;
      endcase
    end
  end

  // Select staging; name field 1, mode field 2
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset || (i_rx_valid && (i_rx_char == CH_DOLLAR)))
    begin
      sel_name_q <= '0;
      sel_nlen_q <= '0;
      sel_mode_q <= '0;
      sel_mlen_q <= '0;
    end
    else if (commit && kind_q == KIND_SELECT)
    begin
      if (fidx_q == 4'd1)
      begin
        sel_name_q <= fname_q;
        sel_nlen_q <= flen_q;
      end
      else if (fidx_q == 4'd2)
      begin
        sel_mode_q <= fchar_q;
        sel_mlen_q <= flen_q;
      end
    end
  end

  // Immediate operating parameters
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      fix_q  <= FIX_AUTO; // [RULE1]
      diff_q <= 1'b0;
      vf_q   <= '0;
      ppsw_q <= PPSW_SHIPPED;
      dr_q   <= DR_SHIPPED;
    end
    else if (done_ok && kind_q == KIND_SETUP)
    begin
      if (s_fix_v_q)  fix_q  <= s_fix_q; // [RULE12]
      if (s_diff_v_q) diff_q <= s_diff_q;
      if (s_vf_v_q)   vf_q   <= s_vf_q;
      if (s_ppsw_v_q) ppsw_q <= s_ppsw_q;
      if (s_dr_v_q)   dr_q   <= s_dr_q;
    end
  end

  // Baud and pulse mode only move to active on a restart event or a REG_CTRL write with bit 0 set
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      baud_q      <= BAUD_SHIPPED; // [RULE1]
      pps_q       <= 1'b1;
      baud_pend_q <= BAUD_SHIPPED;
      pps_pend_q  <= 1'b1;
    end
    else
    begin
      if (done_ok && kind_q == KIND_SETUP && s_baud_v_q)
        baud_pend_q <= s_baud_q;
      if (done_ok && kind_q == KIND_SETUP && s_ppsm_v_q)
        pps_pend_q <= s_ppsm_q;
      if (i_restart_evt || (wr_pend_q && wr_addr_q == REG_CTRL && i_hwdata[0]))
      begin
        baud_q <= baud_pend_q; // [RULE12]
        pps_q  <= pps_pend_q;
      end
    end
  end

  // Output set, almanac transfer and binary mode
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
      mask_q <= MASK_SHIPPED; // [RULE1]
    else if (done_ok && kind_q == KIND_SELECT && sel_valid)
      mask_q <= new_mask; // [RULE13]
    else if (wr_pend_q && wr_addr_q == REG_OUTEN)
      mask_q <= i_hwdata[NSENT-1:0] & ~MASK_BEACON & MASK_ALL | i_hwdata[8:0] & MASK_BEACON;
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
      alm_q <= 1'b0;
    else if (done_ok && kind_q == KIND_SELECT && sel_valid && sel_alm)
      alm_q <= 1'b1; // [RULE17]
    else if (i_almanac_done)
      alm_q <= 1'b0;
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
      bin_q <= 1'b0;
    else if (done_ok && kind_q == KIND_SELECT && sel_valid && sel_mode_q == CH_G)
      bin_q <= 1'b1; // [RULE18]
  end

  // Completed-sentence counters
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      n_ok_q  <= '0;
      n_bad_q <= '0;
    end
    else if (done_ok && kind_q == KIND_SETUP)
      n_ok_q <= n_ok_q + 8'd1;
    else if (done_ok && kind_q == KIND_SELECT)
    begin
      if (sel_valid)
        n_ok_q <= n_ok_q + 8'd1;
      else
        n_bad_q <= n_bad_q + 8'd1; // [RULE16]
    end
  end

  // Registered outputs
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      o_fix_mode     <= FIX_AUTO;
      o_diff_only    <= 1'b0;
      o_vel_filter   <= '0;
      o_dr_time_s    <= DR_SHIPPED;
      o_baud_code    <= BAUD_SHIPPED;
      o_pps_enable   <= 1'b1;
      o_pps_width_ms <= 10'(PPSW_SHIPPED + 6'd1) * PPS_STEP_MS;
      o_out_enable   <= MASK_SHIPPED;
      o_almanac_busy <= 1'b0;
      o_binary_mode  <= 1'b0;
      o_burst_bits   <= burst_of(MASK_SHIPPED);
      o_cmd_done     <= 1'b0;
    end
    else
    begin
      o_fix_mode     <= fix_q;
      o_diff_only    <= diff_q;
      o_vel_filter   <= vf_q;
      o_dr_time_s    <= dr_q;
      o_baud_code    <= baud_q;
      o_pps_enable   <= pps_q;
      o_pps_width_ms <= 10'(ppsw_q + 6'd1) * PPS_STEP_MS; // [RULE10]
      // Periodic output held off while the almanac is being sent
      o_out_enable   <= alm_q ? 9'h000 : mask_q; // [RULE17]
      o_almanac_busy <= alm_q;
      o_binary_mode  <= bin_q;
      o_burst_bits   <= alm_q ? 16'h0000 : burst_of(mask_q); // [RULE19] [RULE20]
      o_cmd_done     <= done_ok && (kind_q == KIND_SETUP
                                    || (kind_q == KIND_SELECT && sel_valid));
    end
  end

  // AHB-Lite slave: zero wait states, always OKAY
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      wr_pend_q   <= 1'b0;
      wr_addr_q   <= '0;
      o_hrdata    <= '0;
      o_hreadyout <= 1'b1;
      o_hresp     <= 1'b0;
    end
    else
    begin
      o_hreadyout <= 1'b1;
      o_hresp     <= 1'b0;
      wr_pend_q   <= i_hsel && i_hready && i_htrans == HTRANS_NONSEQ && i_hwrite;
      wr_addr_q   <= i_haddr;
      if (i_hsel && i_hready && i_htrans == HTRANS_NONSEQ && !i_hwrite)
      begin
        unique case (i_haddr)
          REG_SETUP: o_hrdata <= {3'h0, dr_q, 2'h0, ppsw_q, vf_q, 5'h0, diff_q, fix_q};
          REG_PORT:  o_hrdata <= {14'h0, alm_q, bin_q, 3'h0, pps_pend_q, 1'b0,
                                  baud_pend_q, 3'h0, pps_q, 1'b0, baud_q};
          REG_OUTEN: o_hrdata <= {23'h0, mask_q};
          REG_STATS: o_hrdata <= {16'h0, n_bad_q, n_ok_q};
          default:   o_hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ==== nmea_setup_parser_chk.sv ====
// Concurrent checks on the sentence interpreter outputs
`default_nettype none
module nmea_setup_parser_chk
  import nmea_cfg_pkg::*;
(
  input wire logic        i_clk_sys,
  input wire logic        i_reset,
  input wire logic        i_rx_valid,
  input wire logic [7:0]  i_rx_char,
  input wire logic        i_restart_evt,
  input wire logic        i_almanac_done,
  input wire logic [1:0]  o_fix_mode,
  input wire logic [2:0]  o_baud_code,
  input wire logic        o_pps_enable,
  input wire logic [9:0]  o_pps_width_ms,
  input wire logic [8:0]  o_out_enable,
  input wire logic        o_almanac_busy,
  input wire logic        o_binary_mode,
  input wire logic [15:0] o_burst_bits,
  input wire logic        o_cmd_done
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);
  a_done_pulse: assert property (o_cmd_done |=> !o_cmd_done)
    else $error("done pulse too long");
  a_done_after_lf: assert property ($rose(o_cmd_done) |->
    $past(i_rx_valid, 1) && $past(i_rx_char, 1) == CH_LF)
    else $error("done without line feed");
  a_restart_only: assert property (
    ($changed(o_baud_code) || $changed(o_pps_enable)) |-> $past(i_restart_evt, 2))
    else $error("baud or pulse mode changed without restart");
  a_busy_mute: assert property (o_almanac_busy |->
    o_out_enable == 9'h000 && o_burst_bits == 16'h0000)
    else $error("periodic output during almanac");
  a_busy_clear: assert property (
    o_almanac_busy && i_almanac_done |-> ##[1:3] !o_almanac_busy)
    else $error("almanac busy stuck");
  a_binary_sticky: assert property (o_binary_mode |=> o_binary_mode)
    else $error("binary mode dropped");
  a_width_range: assert property (o_pps_width_ms % 10'h014 == 10'h000 &&
    o_pps_width_ms >= 10'h014 && o_pps_width_ms <= 10'h3D4)
    else $error("pulse width off grid");
  a_burst_step: assert property (o_burst_bits % 16'h000A == 16'h0000 &&
    o_burst_bits <= 16'h1022)
    else $error("burst length off");
  a_fix_legal: assert property (o_fix_mode != 2'h3)
    else $error("fix mode code unused");
endmodule
bind nmea_setup_parser nmea_setup_parser_chk u_chk (.i_clk_sys, .i_reset, .i_rx_valid,
  .i_rx_char, .i_restart_evt, .i_almanac_done, .o_fix_mode, .o_baud_code, .o_pps_enable,
  .o_pps_width_ms, .o_out_enable, .o_almanac_busy, .o_binary_mode, .o_burst_bits,
  .o_cmd_done);
`default_nettype wire

// ==== test_gps_nmea_setup_cmd_parser.sv ====
// Self-checking bench for the setup sentence interpreter
`default_nettype none
module test_gps_nmea_setup_cmd_parser
  import nmea_cfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_clk_sys, i_reset, i_restart_evt, i_almanac_done, i_hsel, i_hwrite;
  logic        i_rx_valid, o_hreadyout, o_hresp, o_diff_only, o_pps_enable;
  logic        o_almanac_busy, o_binary_mode, o_cmd_done, seen;
  logic [7:0]  i_rx_char, i_haddr, o_vel_filter;
  logic [1:0]  i_htrans, o_fix_mode;
  logic [2:0]  i_hsize, o_baud_code;
  logic [31:0] i_hwdata, o_hrdata, rd;
  logic [4:0]  o_dr_time_s;
  logic [9:0]  o_pps_width_ms;
  logic [8:0]  o_out_enable;
  logic [15:0] o_burst_bits;
  wire logic   i_hready;
  int          bad_count, num_checks;
  assign i_hready = o_hreadyout;
  nmea_setup_parser dut (.*);
  nmea_host_model host (.i_clk_sys, .o_rx_valid(i_rx_valid), .o_rx_char(i_rx_char));
  initial i_clk_sys = 1'b0;
  always #2 i_clk_sys = ~i_clk_sys;
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_clk_sys);
    i_hsel   <= 1'b1;
    i_htrans <= HTRANS_NONSEQ;
    i_haddr  <= a;
    i_hwrite <= w;
    do begin @(posedge i_clk_sys); n++; end while (i_hready !== 1'b1 && n < 50);
    i_hsel   <= 1'b0;
    i_htrans <= 2'h0;
    i_hwdata <= d;
    do begin @(posedge i_clk_sys); n++; end while (i_hready !== 1'b1 && n < 50);
    rd = o_hrdata;
    if (n >= 50)
    begin
      bad_count++;
      conclude();
    end
  endtask
  // Done pulse stands only in the cycle after the line feed edge
  task automatic sent(input logic [39:0] nm, input string f, input logic ok);
    seen = 1'b0;
    host.send(nm, f, 1'b1);
    repeat (6)
    begin
      #1;
      seen = seen | o_cmd_done;
      @(posedge i_clk_sys);
    end
    #1;
    chk(seen, ok);
  endtask
  task automatic pulse(input bit alm);
    @(posedge i_clk_sys);
    if (alm) i_almanac_done <= 1'b1; else i_restart_evt <= 1'b1;
    @(posedge i_clk_sys);
    i_almanac_done <= 1'b0;
    i_restart_evt  <= 1'b0;
    repeat (3) @(posedge i_clk_sys);
    #1;
  endtask
  initial
  begin
    {bad_count, num_checks, i_restart_evt, i_almanac_done, i_hsel, i_hwrite} = '0;
    {i_haddr, i_htrans, i_hwdata} = '0;
    i_hsize = 3'h2;
    i_reset = 1'b1;
    repeat (10) @(posedge i_clk_sys);
    i_reset <= 1'b0;
    @(posedge i_clk_sys);
    #1;
    chk({o_baud_code, o_pps_enable, o_pps_width_ms}, {3'h1, 1'b1, 10'h050});
    chk({o_out_enable, o_burst_bits}, {MASK_SHIPPED, 16'h0334});
    sent(NAME_SETUP, ",3,,,,,,,,D,,200,1,4,12", 1'b1);
    chk({o_fix_mode, o_diff_only, o_vel_filter}, {FIX_3D, 1'b1, 8'hC8});
    chk({o_pps_width_ms, o_dr_time_s}, {10'h064, 5'h0C});
    chk(o_pps_enable, 1'b1);
    pulse(0);
    chk(o_pps_enable, 1'b0);
    sent(NAME_SETUP, ",A,,,,,,,,A,,0,2,48*3F", 1'b1);
    chk({o_fix_mode, o_diff_only, o_vel_filter}, {FIX_AUTO, 1'b0, 8'h00});
    chk({o_pps_width_ms, o_dr_time_s}, {10'h3D4, 5'h0C});
    pulse(0);
    chk(o_pps_enable, 1'b1);
    sent(NAME_SETUP, ",,,,,,,,,,,256,,49,31", 1'b1);
    chk({o_vel_filter, o_pps_width_ms, o_dr_time_s}, {8'h00, 10'h3D4, 5'h0C});
    for (int c = 1; c <= 7; c++)
    begin
      sent(NAME_SETUP, $sformatf(",,,,,,,,,,%0d", c), 1'b1);
      pulse(0);
      chk(o_baud_code, c[2:0]);
    end
    host.send(NAME_SETUP, ",2", 1'b0);
    sent(NAME_SETUP, ",,,,,,,,,,,255,,0,30", 1'b1);
    chk({o_fix_mode, o_vel_filter, o_pps_width_ms}, {FIX_AUTO, 8'hFF, 10'h014});
    sent(NAME_SELECT, ",GPVTG,1", 1'b1);
    chk({o_out_enable, o_burst_bits}, {9'h042, 16'h04D8});
    sent(NAME_SELECT, ",GPGGA,0", 1'b1);
    sent(NAME_SELECT, ",GPXYZ,1", 1'b0);
    sent(NAME_SELECT, ",GPGGA,9", 1'b0);
    chk({o_out_enable, o_burst_bits}, {9'h040, 16'h01A4});
    sent(NAME_SELECT, ",,2", 1'b1);
    chk({o_out_enable, o_burst_bits}, {MASK_BEACON, 16'h0000});
    sent(NAME_SELECT, ",ABCDE,3", 1'b1);
    chk({o_out_enable, o_burst_bits}, {MASK_ALL, 16'h1022});
    sent(NAME_SELECT, ",X,4", 1'b1);
    chk({o_out_enable, o_burst_bits}, {9'h01F, 16'h0CC6});
    sent(NAME_SELECT, ",GPALM,1", 1'b1);
    chk({o_almanac_busy, o_out_enable, o_burst_bits}, {1'b1, 25'h0});
    pulse(1);
    chk({o_almanac_busy, o_out_enable}, {1'b0, 9'h01F});
    bus(1'b1, REG_OUTEN, 32'h0000_0003);
    bus(1'b0, REG_OUTEN, 32'h0);
    chk(rd, 32'h0000_0003);
    bus(1'b0, REG_SETUP, 32'h0);
    chk(rd, 32'h1E00_FF00);
    bus(1'b0, REG_PORT, 32'h0);
    chk(rd, 32'h0000_1717);
    bus(1'b0, REG_STATS, 32'h0);
    chk(rd, 32'h0000_0211);
    bus(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h0);
    chk({o_hresp, o_hreadyout}, 2'b01);
    chk(o_out_enable, 9'h003);
    sent(NAME_SELECT, ",,G", 1'b1);
    chk(o_binary_mode, 1'b1);
    @(posedge i_clk_sys);
    i_reset <= 1'b1;
    repeat (2) @(posedge i_clk_sys);
    i_reset <= 1'b0;
    @(posedge i_clk_sys);
    #1;
    chk({o_binary_mode, o_out_enable}, {1'b0, MASK_SHIPPED});
    conclude();
  end
endmodule
`default_nettype wire
